// File: rtl/cfm_pkg.sv
// package: constants, carriers and reset values of the fatal-error monitor
//
// Overview of operation
// - a lamp_primary_a error on a port puts out that port's lamp
// - each port reset bit reinitialises its own port only
// - a fatal error during execution stops the controller
// - a fatal error forces every controller output off
// - a power interruption leaves every lamp unlit
// - other fatal errors light the power and alarm lamps
// - run output inactive while a fatal error is latched
// - supply lost 10 ms or longer is fatal with code 00
// - scan cycle past the watchdog limit is fatal without code
// - halt instruction at cycle time 120 to 130 ms gives 9F
// - memory faults give F1 and set one flag per cause
// - a program with no end instruction gives F0
// - rack bus fault gives C0 to C2, low digit is the rack
// - unit configuration conflicts give E1
// - word assignment mismatch gives E0
// - fatal halt instruction latches the user code 01 to 99
package cfm_pkg;
  // ----------
  // timing
  // ----------
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned PWR_LOSS_MS  = 10;
  localparam int unsigned WDT_MS       = 130;
  localparam int unsigned NEAR_MS      = 120;
  localparam int unsigned PWR_LOSS_CYC = PWR_LOSS_MS * 1000 * CLK_MHZ;
  localparam int unsigned WDT_CYC      = WDT_MS * 1000 * CLK_MHZ;
  localparam int unsigned NEAR_CYC     = NEAR_MS * 1000 * CLK_MHZ;
  // ----------
  // registers
  // ----------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_FATAL = 8'h04;
  localparam logic [7:0] OFS_WDT   = 8'h08;
  localparam logic [7:0] OFS_CYCLE = 8'h0C;
  localparam logic [7:0] OFS_SREF  = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam int CTRL_PERIPH = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int IRQ_W       = 3;
  localparam int MEM_SETUP   = 0;
  localparam int MEM_BOOT    = 4;
  localparam logic [15:0]      SREF_RST  = 16'h0000;
  localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;
  // ----------
  // codes and areas
  // ----------
  localparam logic [7:0]  CODE_PWR   = 8'h00;
  localparam logic [7:0]  CODE_NEAR  = 8'h9F;
  localparam logic [7:0]  CODE_MEM   = 8'hF1;
  localparam logic [7:0]  CODE_END   = 8'hF0;
  localparam logic [7:0]  CODE_BUS   = 8'hC0;
  localparam logic [7:0]  CODE_UNIT  = 8'hE1;
  localparam logic [7:0]  CODE_IOTBL = 8'hE0;
  localparam logic [13:0] SETUP_FIRST = 14'h19C8;
  localparam logic [13:0] SETUP_LAST  = 14'h19FF;
  // ----------
  // carriers
  // ----------
  typedef struct packed {
    logic       prog_csum;
    logic       exp_csum;
    logic       cassette;
    logic       autoboot;
    logic       end_missing;
    logic [2:0] io_bus;
    logic [3:0] unit_cfg;
    logic       io_table;
    logic       periph_lamp_primary_a;
    logic       serial_lamp_primary_a;
  } cfm_err_in_t;
  typedef struct packed {
    logic power_lamp;
    logic run_lamp;
    logic alarm_error_lamp;
    logic lamp_primary_a;
    logic lamp_primary_a_lamp_secondary;
  } cfm_lamp_t;
  typedef struct packed {
    logic       fatal;
    logic       code_ok;
    logic       pwr;
    logic [4:0] mem;
    logic [7:0] code;
  } cfm_fatal_t;
  localparam cfm_lamp_t LAMP_RST = '{power_lamp: 1'h1, lamp_primary_a: 1'h1,
                                     lamp_primary_a_lamp_secondary: 1'h1, default: 1'h0};
endpackage

// File: rtl/cfm_duration.sv
// module: saturating duration counter
`timescale 1ns/100ps
module cfm_duration #(
  parameter int unsigned W = 32 // counter width
) (
  input  wire logic         clk,     // system clock
  input  wire logic         rst_n,   // async reset, low
  input  wire logic         cnt_en,  // count this cycle
  input  wire logic         cnt_clr, // back to zero
  output wire logic [W-1:0] count    // cycles counted
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cfm_dur_st_t;
  cfm_dur_st_t s_q;
  cfm_dur_st_t s_d;

  // clear wins, count stops at all ones
  always_comb begin
    s_d = s_q;
    if (cnt_clr) begin
      s_d.cnt = '0;
    end else if (cnt_en && (s_q.cnt != '1)) begin
      s_d.cnt = s_q.cnt + 1'h1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
endmodule

// File: rtl/cfm_setup_csum.sv
// module: checksum over the setup area of data memory
`timescale 1ns/100ps
module cfm_setup_csum #(
  parameter int unsigned W = 16 // word width
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst_n,    // async reset, low
  input  wire logic         dm_valid, // word strobe
  input  wire logic [13:0]  dm_addr,  // word address
  input  wire logic [W-1:0] dm_data,  // word data
  input  wire logic         check,    // compare and restart
  input  wire logic [W-1:0] ref_sum,  // expected sum
  output wire logic         bad       // mismatch pulse
);
  typedef struct packed {
    logic [W-1:0] sum;
    logic         bad;
  } cfm_csum_st_t;
  cfm_csum_st_t s_q;
  cfm_csum_st_t s_d;

  // sum words inside the setup area, compare on check
  always_comb begin
    s_d = s_q;
    s_d.bad = check && (s_q.sum != ref_sum);
    if (check) begin
      s_d.sum = '0;
    end else if (dm_valid && (dm_addr >= cfm_pkg::SETUP_FIRST)
                 && (dm_addr <= cfm_pkg::SETUP_LAST)) begin
      s_d.sum = s_q.sum + dm_data;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bad = s_q.bad;
endmodule

// File: rtl/cfm_top.sv
// module: fatal-error monitor with apb registers
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
module cfm_top #(
  parameter int unsigned PWR_LOSS_CYC = cfm_pkg::PWR_LOSS_CYC, // supply loss
  parameter int unsigned WDT_CYC      = cfm_pkg::WDT_CYC,      // watchdog reset
  parameter int unsigned NEAR_CYC     = cfm_pkg::NEAR_CYC      // near limit
) (
  input  wire logic                 CLK_SYS,                // system clock
  input  wire logic                 RESETN,                 // async reset, low
  input  wire logic                 PSEL,                   // apb select
  input  wire logic                 PENABLE,                // apb access
  input  wire logic                 PWRITE,                 // apb write
  input  wire logic [7:0]           PADDR,                  // apb address
  input  wire logic [31:0]          PWDATA,                 // apb write data
  output wire logic [31:0]          PRDATA,                 // apb read data
  output wire logic                 PREADY,                 // apb ready
  output wire logic                 PSLVERR,                // apb error
  input  wire logic                 RUN_MODE,               // execution begun
  input  wire logic                 SCAN_END,               // scan end pulse
  input  wire logic                 PWR_OK,                 // supply present
  input  wire cfm_pkg::cfm_err_in_t ERR_IN,                 // fault levels
  input  wire logic                 FATAL_HALT_INSTRUCTION, // halt pulse
  input  wire logic [7:0]           ERROR_CODE_NUMBER,      // user code
  input  wire logic                 RESTART,                // restart pulse
  input  wire logic                 DM_VALID,               // word strobe
  input  wire logic [13:0]          DM_ADDR,                // word address
  input  wire logic [15:0]          DM_DATA,                // word data
  input  wire logic                 SETUP_CHECK,            // compare sum
  output wire logic                 HALT,                   // stop execution
  output wire logic                 OUTPUTS_OFF,            // outputs off
  output wire logic                 RUN_OUT,                // run output
  output wire cfm_pkg::cfm_lamp_t   LAMPS,                  // lamps
  output wire logic                 PERIPH_PORT_RESET,      // port reinit
  output wire logic                 SERIAL_PORT_RESET,      // port reinit
  output wire logic                 IRQ                     // interrupt
);
  // ----------
  // state
  // ----------
  typedef struct packed {
    cfm_pkg::cfm_fatal_t       f;
    logic [1:0]                lamp_primary_a_err;
    logic [1:0]                port_rst;
    logic                      run_out;
    cfm_pkg::cfm_lamp_t        lamp;
    logic [31:0]               wdt_lim;
    logic [31:0]               cyc_last;
    logic [15:0]               setup_ref;
    logic [cfm_pkg::IRQ_W-1:0] irq_stat;
    logic [cfm_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0]               rdata;
    logic                      slverr;
  } cfm_top_st_t;

  localparam cfm_top_st_t ST_RST = '{wdt_lim:   32'(WDT_CYC),
                                     lamp:      cfm_pkg::LAMP_RST,
                                     setup_ref: cfm_pkg::SREF_RST,
                                     irq_mask:  cfm_pkg::IMASK_RST,
                                     default:   '0};

  cfm_top_st_t               s_q;
  cfm_top_st_t               s_d;
  logic [31:0]               pwr_cnt;
  logic [31:0]               cyc_cnt;
  logic                      setup_bad;
  logic [4:0]                mem_cause;
  logic                      pwr_det;
  logic                      wdt_det;
  logic                      near_win;
  logic                      mem_det;
  logic                      bus_det;
  logic                      unit_det;
  logic                      hi_bus;
  logic                      hi_unit;
  logic                      hi_tbl;
  logic                      det_hw;
  logic                      take;
  logic                      wr;
  logic                      rd_stat;
  logic [1:0]                new_lamp_primary_a;
  logic [cfm_pkg::IRQ_W-1:0] stat_clr;

  // lowest faulty rack number
  function automatic logic [1:0] rack_of(input logic [2:0] b);
    logic [1:0] r;
    r = 2'h2;
    if (b[1]) begin
      r = 2'h1;
    end
    if (b[0]) begin
      r = 2'h0;
    end
    return r;
  endfunction

  // ----------
  // duration counters and checksum
  // ----------
  // supply-loss time, cleared as soon as supply returns
  cfm_duration #(
    .W(32)
  ) u_pwr (
    .clk     (CLK_SYS),
    .rst_n   (RESETN),
    .cnt_en  (~PWR_OK),
    .cnt_clr (PWR_OK),
    .count   (pwr_cnt)
  );

  // scan-cycle time, restarted at each scan end
  cfm_duration #(
    .W(32)
  ) u_cyc (
    .clk     (CLK_SYS),
    .rst_n   (RESETN),
    .cnt_en  (RUN_MODE),
    .cnt_clr (SCAN_END | ~RUN_MODE),
    .count   (cyc_cnt)
  );

  // setup-area checksum
  cfm_setup_csum #(
    .W(16)
  ) u_csum (
    .clk      (CLK_SYS),
    .rst_n    (RESETN),
    .dm_valid (DM_VALID),
    .dm_addr  (DM_ADDR),
    .dm_data  (DM_DATA),
    .check    (SETUP_CHECK),
    .ref_sum  (s_q.setup_ref),
    .bad      (setup_bad)
  );

  // ----------
  // fault detection
  // ----------
  // detectors, listed in priority order except near_win, which ranks last
  assign pwr_det   = pwr_cnt >= 32'(PWR_LOSS_CYC);
  assign wdt_det   = (s_q.wdt_lim != '0) && (cyc_cnt >= s_q.wdt_lim);
  assign near_win  = (cyc_cnt >= 32'(NEAR_CYC)) && !wdt_det;
  assign mem_cause = {ERR_IN.autoboot, ERR_IN.cassette, ERR_IN.exp_csum,
                      ERR_IN.prog_csum, setup_bad};
  assign mem_det   = |mem_cause;
  assign bus_det   = |ERR_IN.io_bus;
  assign unit_det  = |ERR_IN.unit_cfg;
  assign hi_bus    = pwr_det | wdt_det | mem_det | ERR_IN.end_missing;
  assign hi_unit   = hi_bus | bus_det;
  assign hi_tbl    = hi_unit | unit_det;
  assign det_hw    = hi_tbl | ERR_IN.io_table;

  // a fault is taken while running and no error is held
  assign take = RUN_MODE && (det_hw || FATAL_HALT_INSTRUCTION)
                && (!s_q.f.fatal || RESTART);

  // ----------
  // apb decode
  // ----------
  assign wr      = PSEL && PENABLE && PWRITE;
  assign rd_stat = PSEL && PENABLE && !PWRITE && (PADDR == cfm_pkg::OFS_ISTAT);

  // ----------
  // next state
  // ----------
  always_comb begin
    s_d      = s_q;
    new_lamp_primary_a = 2'h0;
    stat_clr = '0;
    // restart drops the held error, a fault seen now still wins
    if (RESTART) begin
      s_d.f = '0;
    end
    if (RUN_MODE) begin
      s_d.f.mem = s_d.f.mem | mem_cause;
    end
    // latch the code of the highest-priority fault
    if (take) begin
      s_d.f.fatal   = 1'h1;
      s_d.f.code_ok = 1'h1;
      s_d.f.pwr     = 1'h0;
      if (pwr_det) begin
        s_d.f.pwr  = 1'h1;
        s_d.f.code = cfm_pkg::CODE_PWR;
      end else if (wdt_det) begin
        s_d.f.code_ok = 1'h0;
        s_d.f.code    = '0;
      end else if (mem_det) begin
        s_d.f.code = cfm_pkg::CODE_MEM;
      end else if (ERR_IN.end_missing) begin
        s_d.f.code = cfm_pkg::CODE_END;
      end else if (bus_det) begin
        s_d.f.code = cfm_pkg::CODE_BUS | {6'h00, rack_of(ERR_IN.io_bus)};
      end else if (unit_det) begin
        s_d.f.code = cfm_pkg::CODE_UNIT;
      end else if (ERR_IN.io_table) begin
        s_d.f.code = cfm_pkg::CODE_IOTBL;
      end else if (near_win) begin
        s_d.f.code = cfm_pkg::CODE_NEAR;
      end else begin
        s_d.f.code = ERROR_CODE_NUMBER;
      end
    end

    // port reset bits pulse for one cycle
    s_d.port_rst = 2'h0;
    if (wr) begin
      case (PADDR)
        cfm_pkg::OFS_CTRL: begin
          s_d.port_rst = {PWDATA[cfm_pkg::CTRL_SERIAL],
                          PWDATA[cfm_pkg::CTRL_PERIPH]};
        end
        cfm_pkg::OFS_WDT: begin
          s_d.wdt_lim = PWDATA;
        end
        cfm_pkg::OFS_SREF: begin
          s_d.setup_ref = PWDATA[15:0];
        end
        cfm_pkg::OFS_IMASK: begin
          s_d.irq_mask = PWDATA[cfm_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // lamp_primary_a errors held until own port reset, set wins
    s_d.lamp_primary_a_err = (s_q.lamp_primary_a_err & ~s_q.port_rst)
                   | {ERR_IN.serial_lamp_primary_a, ERR_IN.periph_lamp_primary_a};
    new_lamp_primary_a = s_d.lamp_primary_a_err & ~s_q.lamp_primary_a_err;

    // last completed scan time
    if (SCAN_END && RUN_MODE) begin
      s_d.cyc_last = cyc_cnt;
    end

    // read clears only the bits that were reported
    if (rd_stat) begin
      stat_clr = s_q.rdata[cfm_pkg::IRQ_W-1:0];
    end
    s_d.irq_stat = (s_q.irq_stat & ~stat_clr) | {new_lamp_primary_a, take};

    // read data captured in the setup phase
    if (PSEL && !PENABLE) begin
      s_d.slverr = 1'h0;
      case (PADDR)
        cfm_pkg::OFS_CTRL: begin
          s_d.rdata = '0;
        end
        cfm_pkg::OFS_FATAL: begin
          s_d.rdata = {14'h0000, s_q.lamp_primary_a_err, s_q.f};
        end
        cfm_pkg::OFS_WDT: begin
          s_d.rdata = s_q.wdt_lim;
        end
        cfm_pkg::OFS_CYCLE: begin
          s_d.rdata = s_q.cyc_last;
        end
        cfm_pkg::OFS_SREF: begin
          s_d.rdata = {16'h0000, s_q.setup_ref};
        end
        cfm_pkg::OFS_ISTAT: begin
          s_d.rdata = {29'h00000000, s_q.irq_stat};
        end
        cfm_pkg::OFS_IMASK: begin
          s_d.rdata = {29'h00000000, s_q.irq_mask};
        end
        default: begin
          s_d.rdata  = '0;
          s_d.slverr = 1'h1;
        end
      endcase
    end

    // run output and lamps follow the next error state
    s_d.run_out = RUN_MODE && !s_d.f.fatal;
    s_d.lamp.run_lamp            = s_d.run_out;
    s_d.lamp.power_lamp          = !s_d.f.pwr;
    s_d.lamp.alarm_error_lamp    = s_d.f.fatal && !s_d.f.pwr;
    s_d.lamp.lamp_primary_a      = !s_d.lamp_primary_a_err[0] && !s_d.f.pwr;
    s_d.lamp.lamp_primary_a_lamp_secondary = !s_d.lamp_primary_a_err[1] && !s_d.f.pwr;
  end

  // state register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------
  // outputs
  // ----------
  assign HALT              = s_q.f.fatal;
  assign OUTPUTS_OFF       = s_q.f.fatal;
  assign RUN_OUT           = s_q.run_out;
  assign LAMPS             = s_q.lamp;
  assign PERIPH_PORT_RESET = s_q.port_rst[0];
  assign SERIAL_PORT_RESET = s_q.port_rst[1];
  assign PRDATA            = s_q.rdata;
  assign PREADY            = PSEL && PENABLE;
  assign PSLVERR           = PSEL && PENABLE && s_q.slverr;
  assign IRQ               = |(s_q.irq_stat & s_q.irq_mask);

  // ----------
  // checks
  // ----------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  // controller stopped with outputs off
  sequence seq_stopped;
    HALT && OUTPUTS_OFF && !RUN_OUT;
  endsequence

  // error held across a cycle with no restart
  sequence seq_held;
    HALT && !RESTART ##1 HALT;
  endsequence

  AST_LAMP_A: assert property (ERR_IN.periph_lamp_primary_a |=> !LAMPS.lamp_primary_a)
    else $error("peripheral lamp_primary_a lamp still lit");
  AST_LAMP_B: assert property (ERR_IN.serial_lamp_primary_a |=> !LAMPS.lamp_primary_a_lamp_secondary)
    else $error("serial lamp_primary_a lamp still lit");
  AST_PORT_A: assert property (wr && (PADDR == cfm_pkg::OFS_CTRL) && PWDATA[0] && !PWDATA[1]
    |=> PERIPH_PORT_RESET && !SERIAL_PORT_RESET)
    else $error("peripheral port reset wrong");
  AST_PORT_B: assert property (wr && (PADDR == cfm_pkg::OFS_CTRL) && PWDATA[1] && !PWDATA[0]
    |=> SERIAL_PORT_RESET && !PERIPH_PORT_RESET)
    else $error("serial port reset wrong");
  AST_STOP: assert property (take |=> seq_stopped)
    else $error("fatal error did not stop controller");
  AST_OFF: assert property ($fell(OUTPUTS_OFF) |-> $past(RESTART))
    else $error("outputs released without restart");
  AST_DARK: assert property (HALT && s_q.f.pwr |-> LAMPS == '0)
    else $error("lamp lit on power interruption");
  AST_ALARM: assert property (HALT && !s_q.f.pwr |-> LAMPS.power_lamp && LAMPS.alarm_error_lamp)
    else $error("power or alarm lamp unlit");
  AST_RUN: assert property (HALT |-> !RUN_OUT)
    else $error("run output active during fatal error");
  AST_PWR: assert property (take && pwr_det |=> s_q.f.pwr && (s_q.f.code == cfm_pkg::CODE_PWR))
    else $error("power interruption code wrong");
  AST_WDT: assert property (take && !pwr_det && wdt_det |=> HALT && !s_q.f.code_ok)
    else $error("watchdog error carries a code");
  AST_NEAR: assert property (take && !det_hw && near_win |=> s_q.f.code == cfm_pkg::CODE_NEAR)
    else $error("near-limit halt code wrong");
  AST_MEM: assert property (take && mem_det && !pwr_det && !wdt_det
    |=> s_q.f.code == cfm_pkg::CODE_MEM)
    else $error("memory error code wrong");
  AST_BOOT: assert property (RUN_MODE && ERR_IN.autoboot |=> s_q.f.mem[cfm_pkg::MEM_BOOT])
    else $error("autoboot flag not set");
  AST_CSUM: assert property (RUN_MODE && setup_bad |=> s_q.f.mem[cfm_pkg::MEM_SETUP])
    else $error("setup checksum flag not set");
  AST_END: assert property (take && ERR_IN.end_missing && !pwr_det && !wdt_det && !mem_det
    |=> s_q.f.code == cfm_pkg::CODE_END)
    else $error("missing end code wrong");
  AST_BUS: assert property (take && bus_det && !hi_bus
    |=> s_q.f.code == (cfm_pkg::CODE_BUS | {6'h00, rack_of($past(ERR_IN.io_bus))}))
    else $error("rack bus code wrong");
  AST_UNIT: assert property (take && unit_det && !hi_unit |=> s_q.f.code == cfm_pkg::CODE_UNIT)
    else $error("unit conflict code wrong");
  AST_TBL: assert property (take && ERR_IN.io_table && !hi_tbl |=> s_q.f.code == cfm_pkg::CODE_IOTBL)
    else $error("word assignment code wrong");
  AST_USER: assert property (take && !det_hw && !near_win
    |=> s_q.f.code == $past(ERROR_CODE_NUMBER))
    else $error("user halt code not latched");
  AST_HOLD: assert property (seq_held |-> $stable(s_q.f.code) && $stable(s_q.f.pwr))
    else $error("held error changed without restart");
endmodule

// File: sim/cfm_far_model.sv
// far side model: rack units and the two serial peripherals
`timescale 1ns/100ps
module cfm_far_model (
  input  wire logic                 clk,      // system clock
  input  wire logic                 rst_n,    // async reset, low
  input  wire cfm_pkg::cfm_err_in_t inj,      // faults commanded
  input  wire logic [1:0]           brk,      // link break, periph and serial
  input  wire logic [1:0]           port_rst, // port reinit, periph and serial
  output wire cfm_pkg::cfm_err_in_t err       // fault levels
);
  logic [1:0] bad_q;
  // a broken link stays in error until its own port is reinitialised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_q <= 2'h0;
    end else begin
      bad_q <= (bad_q & ~port_rst) | brk;
    end
  end
  // a port under reinit reports no error
  assign err = inj | {13'h0000, bad_q & ~port_rst};
endmodule

// File: sim/tb_top.sv
// testbench of the fatal-error monitor
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst_n, psel, penable, pwrite, run_mode, scan_end, pwr_ok;
  logic        fh, restart, dmv, scheck, scan_on, err;
  logic [7:0]  paddr, ucode;
  logic [31:0] pwdata, rd;
  logic [13:0] dma;
  logic [15:0] dmd;
  logic [1:0]  brk;
  logic [5:0]  sc = 6'd0;
  wire  [31:0] prdata;
  wire         pready, pslverr, halt, off, run_out, prst, srst, irq;
  cfm_pkg::cfm_err_in_t inj, err_in;
  cfm_pkg::cfm_lamp_t   lamps;
  int          bad_count, num_checks;
  logic [14:0] ftab [10] = '{15'h4000, 15'h2000, 15'h1000, 15'h0800, 15'h0400,
                             15'h0080, 15'h0200, 15'h0300, 15'h0040, 15'h0004};
  logic [7:0]  ctab [10] = '{8'hF1, 8'hF1, 8'hF1, 8'hF1, 8'hF0, 8'hC0, 8'hC2, 8'hC1, 8'hE1, 8'hE0};
  logic [4:0]  mtab [10] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
  logic [13:0] atab [4]  = '{14'd6599, 14'd6600, 14'd6655, 14'd6656};

  cfm_top #(.PWR_LOSS_CYC(20), .WDT_CYC(200), .NEAR_CYC(150)) dut_u (
    .CLK_SYS(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RUN_MODE(run_mode),
    .SCAN_END(scan_end), .PWR_OK(pwr_ok), .ERR_IN(err_in), .FATAL_HALT_INSTRUCTION(fh),
    .ERROR_CODE_NUMBER(ucode), .RESTART(restart), .DM_VALID(dmv), .DM_ADDR(dma), .DM_DATA(dmd),
    .SETUP_CHECK(scheck), .HALT(halt), .OUTPUTS_OFF(off), .RUN_OUT(run_out), .LAMPS(lamps),
    .PERIPH_PORT_RESET(prst), .SERIAL_PORT_RESET(srst), .IRQ(irq));
  cfm_far_model far_u (.clk(clk), .rst_n(rst_n), .inj(inj), .brk(brk), .port_rst({prst, srst}), .err(err_in));

  // ----------
  // helpers
  // ----------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // only pready or the bench watchdog ends this wait
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // restart clears the latched fault
  task automatic clr;
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    wt(2);
  endtask
  task automatic halt_instr(input logic [7:0] c);
    fh <= 1'b1;
    ucode <= c;
    wt(1);
    fh <= 1'b0;
    wt(3);
    apb(1'b0, cfm_pkg::OFS_FATAL, 32'h0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------
  // clock, scan pulses, watchdog
  // ----------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    sc <= (sc == 6'd49) ? 6'd0 : sc + 6'd1;
    scan_end <= scan_on & (sc == 6'd49);
  end
  initial begin
    #100000;
    bad_count++;
    $display("Error at %0t: run timed out", $time);
    final_report;
  end

  // ----------
  // tests
  // ----------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fh, ucode, restart, dmv, dma, dmd, scheck} = '0;
    {run_mode, scan_on, brk, inj, bad_count, num_checks} = '0;
    rst_n = 1'b0;
    pwr_ok = 1'b1;
    wt(3);
    rst_n <= 1'b1;
    run_mode <= 1'b1;
    scan_on <= 1'b1;
    apb(1'b0, cfm_pkg::OFS_WDT, 32'h0);
    chk(rd, 32'd200);
    apb(1'b1, cfm_pkg::OFS_WDT, 32'd180);
    apb(1'b0, cfm_pkg::OFS_WDT, 32'h0);
    chk(rd, 32'd180);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, cfm_pkg::OFS_IMASK, 32'h2);
    apb(1'b0, cfm_pkg::OFS_IMASK, 32'h0);
    chk(rd, 32'h2);
    chk({halt, off, run_out, lamps.run_lamp}, 4'b0011);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      inj <= ftab[i];
      wt(3);
      apb(1'b0, cfm_pkg::OFS_FATAL, 32'h0);
      chk(rd, {16'h0, 3'b110, mtab[i], ctab[i]});
      chk({halt, off, run_out, lamps.run_lamp, lamps.power_lamp, lamps.alarm_error_lamp, irq}, 7'b1100110);
      inj <= '0;
      clr;
    end
    apb(1'b0, cfm_pkg::OFS_FATAL, 32'h0);
    chk(rd, 32'h0);
    $display("test fault table done");
    halt_instr(8'h42);
    chk(rd, 32'h0000_C042);
    clr;
    @(posedge clk iff scan_end === 1'b1);
    scan_on <= 1'b0;
    wt(160);
    halt_instr(8'h42);
    chk(rd, 32'h0000_C09F);
    clr;
    wt(50);
    apb(1'b0, cfm_pkg::OFS_FATAL, 32'h0);
    chk(rd, 32'h0000_8000);
    scan_on <= 1'b1;
    wt(60);
    clr;
    $display("test cycle time done");
    pwr_ok <= 1'b0;
    wt(19);
    pwr_ok <= 1'b1;
    wt(3);
    chk(halt, 1'b0);
    pwr_ok <= 1'b0;
    wt(25);
    chk({halt, off, run_out, lamps}, 8'hC0);
    apb(1'b0, cfm_pkg::OFS_FATAL, 32'h0);
    chk({rd[15], rd[13], rd[7:0]}, 10'h300);
    pwr_ok <= 1'b1;
    clr;
    $display("test power done");
    apb(1'b1, cfm_pkg::OFS_SREF, 32'h5);
    apb(1'b0, cfm_pkg::OFS_SREF, 32'h0);
    chk(rd, 32'h5);
    for (int i = 0; i < 4; i++) begin
      {dmv, dma, dmd} <= {1'b1, atab[i], 16'(i + 1)};
      wt(1);
    end
    {dmv, scheck} <= 2'b01;
    wt(1);
    scheck <= 1'b0;
    wt(4);
    chk(halt, 1'b0);
    scheck <= 1'b1;
    wt(1);
    scheck <= 1'b0;
    wt(4);
    apb(1'b0, cfm_pkg::OFS_FATAL, 32'h0);
    chk(rd, 32'h0000_C1F1);
    clr;
    $display("test checksum done");
    apb(1'b0, cfm_pkg::OFS_ISTAT, 32'h0);
    brk <= 2'b11;
    wt(1);
    brk <= 2'b00;
    wt(2);
    chk({lamps.lamp_primary_a, lamps.lamp_primary_a_lamp_secondary, irq}, 3'b001);
    apb(1'b1, cfm_pkg::OFS_CTRL, 32'h1);
    wt(1);
    chk({prst, srst}, 2'b10);
    wt(2);
    chk({lamps.lamp_primary_a, lamps.lamp_primary_a_lamp_secondary}, 2'b10);
    apb(1'b1, cfm_pkg::OFS_CTRL, 32'h2);
    wt(1);
    chk({prst, srst}, 2'b01);
    wt(2);
    chk({lamps.lamp_primary_a, lamps.lamp_primary_a_lamp_secondary}, 2'b11);
    apb(1'b0, cfm_pkg::OFS_ISTAT, 32'h0);
    chk(rd[2:0], 3'b110);
    wt(2);
    chk(irq, 1'b0);
    // steady scans of 50 cycles record 49 counts
    apb(1'b0, cfm_pkg::OFS_CYCLE, 32'h0);
    chk(rd, 32'd49);
    $display("test lamp_primary_a done");
    final_report;
  end
endmodule
